// ### src/ccc_cfg_top.sv
// Purpose: APB-held clock conditioning config, bits 83 to 32
// Assumes: APB4 master, single clock, PLL core gives a raw lock
// Notes:   shadow word written by software, applied on update
//          bit 80 always reads one; writes to it are dropped
//          a reserved feedback code never reaches the mux
//
// Operation
// - bits 83..81 pick RC or crystal oscillator per clock input
// - bit 80 high resyncs output dividers after an update; read-only
// - bits 79 and 78 route inputs 3 and 2 to their global outputs
// - bit 77 readies input 1 for dynamic PLL configuration
// - bits 76..74 select one of four VCO frequency ranges
// - bits 73..71 drive static input muxes for inputs 3, 2, 1
// - bits 70..66 and 65..61 set local output 3 and 2 delays
// - bits 60..56, 55..51, 50..46 set global 3, 2, primary delays
// - bit 45 inserts the system delay into the feedback path
// - bits 44..40 set the programmable feedback delay
// - bits 39..38 choose direct, delayed or external feedback
// - bits 37..35 and 34..32 pick VCO phase for pairs 3 and 2
// - bits 83..81 exist only in the oscillator-select variant
// - lock goes high once feedback aligns with the reference
`timescale 1ns/1ps
`default_nettype none

module ccc_cfg_top
  import ccc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PLL core status
  input wire logic pll_lock_raw,
  output logic pll_locked,
  // update to the clock path
  output logic config_update_strobe,
  output logic divider_resync_pulse,
  // input source and routing
  output logic osc_source_sel_in3,
  output logic osc_source_sel_in2,
  output logic osc_source_sel_in1,
  output logic divider_resync_enable,
  output logic dynamic_route_in3,
  output logic dynamic_route_in2,
  output logic dynamic_route_in1,
  output logic static_mux_sel_in3,
  output logic static_mux_sel_in2,
  output logic static_mux_sel_in1,
  // VCO and feedback
  output logic [2:0] vco_range_field,
  output logic system_delay_insert,
  output logic [4:0] feedback_delay_code,
  output logic [1:0] feedback_source_sel,
  // output delays and phases
  output logic [4:0] local_out3_delay,
  output logic [4:0] local_out2_delay,
  output logic [4:0] global_out3_delay,
  output logic [4:0] global_out2_delay,
  output logic [4:0] global_primary_delay,
  output logic [2:0] phase_sel_out3,
  output logic [2:0] phase_sel_out2
);

  // ==========================================================
  // fixed bits and writable mask

  // oscillator selects only writable in the capable variant;
  // a narrower variant keeps them at zero in both copies
  localparam ccc_cfg_t OSC_MASK =
    ccc_cfg_t'({3{OSC_SEL_PRESENT}}) << (BIT_OSC_IN1 - CFG_LSB);
  // resync bit never writable; software cannot turn off the
  // divider resync that follows every applied update
  localparam ccc_cfg_t RESYNC_MASK =
    ccc_cfg_t'(1) << (BIT_RESYNC - CFG_LSB);
  // writable bits: all but resync and absent oscillator selects
  localparam ccc_cfg_t WR_MASK =
    ~(RESYNC_MASK | (~OSC_MASK &
    (ccc_cfg_t'(7) << (BIT_OSC_IN1 - CFG_LSB))));
  // value that the protected bits always hold
  localparam ccc_cfg_t CFG_FIXED =
    RESYNC_FIXED ? RESYNC_MASK : '0;

  // ==========================================================
  // state

  // block state apart from the lock path, registered as one word
  typedef struct packed {
    ccc_cfg_t shadow;
    ccc_cfg_t active;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic upd;
    logic resync;
  } ccc_state_t;

  ccc_state_t state_r;
  ccc_state_t state_nxt;
  // lock level after the synchroniser and after qualification
  logic raw_lock_sync;
  logic locked_q;

  // ==========================================================
  // helpers

  // one register word of a config copy; the high word holds
  // bits 83..64 only and its upper bits read as zero
  function automatic logic [31:0] ccc_word(input ccc_cfg_t v,
                                           input logic hi);
    logic [31:0] w;
    if (hi) begin
      w = 32'(v[CFG_MSB:CFG_HI_LSB]);
    end else begin
      w = v[CFG_HI_LSB-1:CFG_LSB];
    end
    return w;
  endfunction

  // byte-lane merge of write data; lanes without a strobe
  // keep what the shadow already holds
  function automatic logic [31:0] ccc_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // address decode; any other offset is answered with an
  // error and has no effect
  function automatic logic ccc_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFF_CFG_LO) || (a == OFF_CFG_HI) ||
           (a == OFF_CTRL) || (a == OFF_STATUS) ||
           (a == OFF_ACT_LO) || (a == OFF_ACT_HI);
  endfunction

  // ==========================================================
  // lock path from the PLL core

  // raw lock arrives from another domain
  // through three stages and an output flop; a level counts once two agree
  ccc_sync3 u_lock_sync (
    .clk(clk),
    .rst(rst),
    .din(pll_lock_raw),
    .dout(raw_lock_sync)
  );

  // lock dropped on every applied update: the core loses
  // alignment while its settings move, and the raw level
  // lags by the synchroniser depth
  ccc_lock_qual u_lock_qual (
    .clk(clk),
    .rst(rst),
    .raw_lock(raw_lock_sync),
    .restart(state_r.upd),
    .locked(locked_q)
  );

  // ==========================================================
  // next state

  always_comb begin
    logic setup;
    logic access;
    logic [31:0] wword;
    logic [31:0] rword;
    ccc_cfg_t nshadow;
    // bus phase decode; the access is taken only in the cycle
    // in which pready stands high
    setup = psel && !penable;
    access = psel && penable && state_r.pready;
    wword = '0;
    rword = '0;
    nshadow = state_r.shadow;
    state_nxt = state_r;
    // update and resync are pulses of one cycle
    state_nxt.upd = 1'b0;
    state_nxt.resync = 1'b0;
    // answer one cycle after setup, with no wait states, so a
    // master never sees pready outside its own access phase
    state_nxt.pready = setup;
    state_nxt.pslverr = setup && !ccc_mapped(paddr);

    // read data captured in setup; it then holds steady for
    // the access phase even if lock moves in between
    if (setup && !pwrite) begin
      case (paddr)
        OFF_CFG_LO: rword = ccc_word(state_r.shadow, 1'b0);
        OFF_CFG_HI: rword = ccc_word(state_r.shadow, 1'b1);
        OFF_ACT_LO: rword = ccc_word(state_r.active, 1'b0);
        OFF_ACT_HI: rword = ccc_word(state_r.active, 1'b1);
        OFF_STATUS: begin
          // lock, pending update and raw lock
          rword[STAT_LOCK_BIT] = locked_q;
          rword[STAT_PEND_BIT] = state_r.shadow != state_r.active;
          rword[STAT_RAW_BIT] = raw_lock_sync;
        end
        default: rword = '0;
      endcase
      state_nxt.prdata = rword;
    end else if (setup) begin
      // writes answer with zero read data
      state_nxt.prdata = '0;
    end

    // writes land in the shadow only
    if (access && pwrite) begin
      case (paddr)
        OFF_CFG_LO: begin
          wword = ccc_merge(ccc_word(state_r.shadow, 1'b0),
                            pwdata, pstrb);
          nshadow[CFG_HI_LSB-1:CFG_LSB] = wword;
        end
        OFF_CFG_HI: begin
          wword = ccc_merge(ccc_word(state_r.shadow, 1'b1),
                            pwdata, pstrb);
          nshadow[CFG_MSB:CFG_HI_LSB] =
            wword[CFG_MSB-CFG_HI_LSB:0];
        end
        OFF_CTRL: begin
          // only lane 0 carries the apply request
          if (pstrb[0] && pwdata[CTRL_UPDATE_BIT]) begin
            state_nxt.upd = 1'b1;
          end
        end
        // status and active copies ignore writes without error
        default: wword = '0;
      endcase
    end
    // protected bits keep fixed values
    state_nxt.shadow = (nshadow & WR_MASK) |
                       (CFG_FIXED & ~WR_MASK);

    // apply shadow to the clock path on update; the word taken
    // is the one held before this edge, and the next write can
    // land no earlier than two cycles later
    if (state_nxt.upd) begin
      state_nxt.active = state_r.shadow;
      // reserved feedback code leaves the mux alone
      if (state_r.shadow[FBSEL_HI:FBSEL_LO] == FBSEL_RESERVED) begin
        state_nxt.active[FBSEL_HI:FBSEL_LO] =
          state_r.active[FBSEL_HI:FBSEL_LO];
      end
      // resync follows the applied bit 80
      state_nxt.resync = state_r.shadow[BIT_RESYNC];
    end
  end

  // ==========================================================
  // state register

  // reset loads the fixed bits, so bit 80 reads one at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r.shadow <= CFG_FIXED;
      state_r.active <= CFG_FIXED;
      state_r.prdata <= '0;
      state_r.pready <= 1'b0;
      state_r.pslverr <= 1'b0;
      state_r.upd <= 1'b0;
      state_r.resync <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // bus and status outputs

  // every output below comes straight from a register
  assign prdata = state_r.prdata;
  assign pready = state_r.pready;
  assign pslverr = state_r.pslverr;
  assign pll_locked = locked_q;
  assign config_update_strobe = state_r.upd;
  assign divider_resync_pulse = state_r.resync;

  // ==========================================================
  // source, routing and mux selects

  // oscillator source per clock input
  assign osc_source_sel_in3 = state_r.active[BIT_OSC_IN3];
  assign osc_source_sel_in2 = state_r.active[BIT_OSC_IN2];
  assign osc_source_sel_in1 = state_r.active[BIT_OSC_IN1];
  // divider resync enable, fixed high
  assign divider_resync_enable = state_r.active[BIT_RESYNC];
  // routing for dynamic control
  assign dynamic_route_in3 = state_r.active[BIT_DYN_IN3];
  assign dynamic_route_in2 = state_r.active[BIT_DYN_IN2];
  assign dynamic_route_in1 = state_r.active[BIT_DYN_IN1];
  // static input multiplexers
  assign static_mux_sel_in3 = state_r.active[BIT_STAT_IN3];
  assign static_mux_sel_in2 = state_r.active[BIT_STAT_IN2];
  assign static_mux_sel_in1 = state_r.active[BIT_STAT_IN1];

  // ==========================================================
  // VCO range and feedback path

  // VCO range, then the feedback path controls
  assign vco_range_field = state_r.active[VCO_HI:VCO_LO];
  assign system_delay_insert = state_r.active[BIT_SYSDLY];
  assign feedback_delay_code =
    state_r.active[FBDLY_HI:FBDLY_LO];
  assign feedback_source_sel =
    state_r.active[FBSEL_HI:FBSEL_LO];

  // ==========================================================
  // output delays

  // local (non-global) outputs
  assign local_out3_delay =
    state_r.active[DLY_L3_HI:DLY_L3_LO];
  assign local_out2_delay =
    state_r.active[DLY_L2_HI:DLY_L2_LO];
  // global outputs
  assign global_out3_delay =
    state_r.active[DLY_G3_HI:DLY_G3_LO];
  assign global_out2_delay =
    state_r.active[DLY_G2_HI:DLY_G2_LO];
  assign global_primary_delay =
    state_r.active[DLY_G1_HI:DLY_G1_LO];

  // ==========================================================
  // VCO phase selects

  // phase for the third and second output pairs
  assign phase_sel_out3 = state_r.active[PH3_HI:PH3_LO];
  assign phase_sel_out2 = state_r.active[PH2_HI:PH2_LO];

endmodule
`default_nettype wire

// ### pkg/ccc_pkg.sv
// Purpose: shared constants for the clock conditioning config block
// Assumes: config word held as bits 83 down to 32, APB data 32 bits
// Notes:   offsets are byte addresses; one aligned word per register

package ccc_pkg;

  // ==========================================================
  // config word span and field positions
  localparam int CFG_LSB = 32;
  localparam int CFG_MSB = 83;
  localparam int CFG_HI_LSB = 64;
  localparam int BIT_OSC_IN3 = 83;
  localparam int BIT_OSC_IN2 = 82;
  localparam int BIT_OSC_IN1 = 81;
  localparam int BIT_RESYNC = 80;
  localparam int BIT_DYN_IN3 = 79;
  localparam int BIT_DYN_IN2 = 78;
  localparam int BIT_DYN_IN1 = 77;
  localparam int VCO_HI = 76;
  localparam int VCO_LO = 74;
  localparam int BIT_STAT_IN3 = 73;
  localparam int BIT_STAT_IN2 = 72;
  localparam int BIT_STAT_IN1 = 71;
  localparam int DLY_L3_HI = 70;
  localparam int DLY_L3_LO = 66;
  localparam int DLY_L2_HI = 65;
  localparam int DLY_L2_LO = 61;
  localparam int DLY_G3_HI = 60;
  localparam int DLY_G3_LO = 56;
  localparam int DLY_G2_HI = 55;
  localparam int DLY_G2_LO = 51;
  localparam int DLY_G1_HI = 50;
  localparam int DLY_G1_LO = 46;
  localparam int BIT_SYSDLY = 45;
  localparam int FBDLY_HI = 44;
  localparam int FBDLY_LO = 40;
  localparam int FBSEL_HI = 39;
  localparam int FBSEL_LO = 38;
  localparam int PH3_HI = 37;
  localparam int PH3_LO = 35;
  localparam int PH2_HI = 34;
  localparam int PH2_LO = 32;

  typedef logic [CFG_MSB:CFG_LSB] ccc_cfg_t;

  // ==========================================================
  // variant and fixed values
  localparam logic OSC_SEL_PRESENT = 1'b1;
  localparam logic RESYNC_FIXED = 1'b1;
  localparam logic [1:0] FBSEL_RESERVED = 2'h3;

  // ==========================================================
  // APB register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CFG_LO = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CFG_HI = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_ACT_LO = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_ACT_HI = 8'h14;
  localparam int CTRL_UPDATE_BIT = 0;
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_PEND_BIT = 1;
  localparam int STAT_RAW_BIT = 2;

  // ==========================================================
  // lock qualification timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int LOCK_QUAL_NS = 1000;
  localparam int LOCK_QUAL_CYC =
    (LOCK_QUAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOCK_CNT_W = 8;

endpackage

// ### src/ccc_sync3.sv
// Purpose: three-stage synchroniser for a pin level
// Assumes: input is asynchronous to clk
// Notes:   output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module ccc_sync3 (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // level in and out
  input wire logic din,
  output logic dout
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } ccc_sync_t;

  ccc_sync_t st_r;
  ccc_sync_t st_nxt;

  // ==========================================================
  // shift and agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.q = st_r.s3;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.q;

endmodule
`default_nettype wire

// ### src/ccc_lock_qual.sv
// Purpose: qualify the PLL core lock level before reporting it
// Assumes: raw lock already synchronised to clk
// Notes:   a restart pulse drops lock until it settles again
`timescale 1ns/1ps
`default_nettype none

module ccc_lock_qual
  import ccc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // lock in, restart, lock out
  input wire logic raw_lock,
  input wire logic restart,
  output logic locked
);

  localparam logic [LOCK_CNT_W-1:0] QUAL_LAST =
    LOCK_CNT_W'(LOCK_QUAL_CYC - 1);

  typedef struct packed {
    logic [LOCK_CNT_W-1:0] cnt;
    logic locked;
  } ccc_lock_t;

  ccc_lock_t st_r;
  ccc_lock_t st_nxt;

  // ==========================================================
  // count stable lock cycles
  always_comb begin
    st_nxt = st_r;
    if (!raw_lock || restart) begin
      st_nxt.cnt = '0;
      st_nxt.locked = 1'b0;
    end else if (st_r.cnt == QUAL_LAST) begin
      st_nxt.locked = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign locked = st_r.locked;

endmodule
`default_nettype wire

// ### dv/ccc_cfg_monitor.sv
// Purpose: port checks on the clock conditioning config block
// Assumes: one clock, async active-high reset
// Notes:   bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none

module ccc_cfg_monitor
  import ccc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  // lock and update
  input wire logic pll_lock_raw,
  input wire logic pll_locked,
  input wire logic config_update_strobe,
  input wire logic divider_resync_pulse,
  input wire logic divider_resync_enable,
  input wire logic [2:0] vco_range_field,
  input wire logic [4:0] feedback_delay_code
);
  // ==========================================================
  // apply request accepted on the bus
  logic go;
  assign go = psel && penable && pready && pwrite && paddr == OFF_CTRL
    && pstrb[0] && pwdata[CTRL_UPDATE_BIT];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // bus answer
  a_setup_answer: assert property (
    psel && !penable |=> pready && penable) else $error("no answer");
  a_ready_single: assert property (
    pready |=> !pready) else $error("pready too long");
  a_err_unmapped: assert property (
    pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > OFF_ACT_HI))
    else $error("bad error response");
  // ==========================================================
  // update and resync
  a_update_strobe: assert property (
    go |=> config_update_strobe ##1 !config_update_strobe)
    else $error("bad update strobe");
  a_strobe_cause: assert property (
    config_update_strobe |-> $past(go)) else $error("stray strobe");
  a_fields_hold: assert property (
    !config_update_strobe |-> $stable(vco_range_field)
    && $stable(feedback_delay_code)) else $error("field moved");
  a_resync_pulse: assert property (
    divider_resync_pulse == (config_update_strobe
    && divider_resync_enable)) else $error("bad resync pulse");
  // ==========================================================
  // lock
  a_lock_drop: assert property (
    !pll_lock_raw [*6] |-> !pll_locked) else $error("lock held");
  a_lock_cause: assert property (
    $rose(pll_locked) |-> $past(pll_lock_raw, 20))
    else $error("early lock");
  a_lock_restart: assert property (
    config_update_strobe |=> !pll_locked) else $error("lock kept");
endmodule

bind ccc_cfg_top ccc_cfg_monitor u_mon (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .pll_lock_raw(pll_lock_raw), .pll_locked(pll_locked),
  .config_update_strobe(config_update_strobe),
  .divider_resync_pulse(divider_resync_pulse),
  .divider_resync_enable(divider_resync_enable),
  .vco_range_field(vco_range_field),
  .feedback_delay_code(feedback_delay_code));
`default_nettype wire

// ### dv/ccc_pll_model.sv
// Purpose: PLL core stand-in giving a raw lock level
// Assumes: settles a fixed span after it is allowed to run
// Notes:   every applied update restarts the settling
`timescale 1ns/1ps
`default_nettype none

module ccc_pll_model #(
  parameter int LOCK_DLY = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control and lock
  input wire logic run,
  input wire logic config_update_strobe,
  output logic pll_lock_raw
);
  int cnt;
  // ==========================================================
  // lock only once aligned; reconfig loses alignment
  always @(posedge clk or posedge rst) begin
    if (rst || !run || config_update_strobe) begin
      cnt <= 0;
      pll_lock_raw <= 1'b0;
    end else if (cnt == LOCK_DLY) begin
      pll_lock_raw <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Purpose: self-checking bench for the config block
// Assumes: 40 MHz clock, reset held 20 cycles
// Notes:   lock comes from the PLL core model
`timescale 1ns/1ps
`default_nettype none

module testbench
  import ccc_pkg::*;
;
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, er, raw, locked, upd, rsp, o3, o2, o1, rse;
  logic d3, d2, d1, s3, s2, s1, sysd;
  logic [2:0] vco, ph3, ph2;
  logic [4:0] fbd, l3, l2, g3, g2, g1;
  logic [1:0] fbs;
  ccc_cfg_t act, cur;
  int num_errors = 0, check_count = 0;
  // active word rebuilt in bit order 83 down to 32
  assign act = {o3, o2, o1, rse, d3, d2, d1, vco, s3, s2, s1, l3, l2,
    g3, g2, g1, sysd, fbd, fbs, ph3, ph2};
  always #12.5 clk = ~clk;

  ccc_cfg_top u_dut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pll_lock_raw(raw), .pll_locked(locked),
    .config_update_strobe(upd), .divider_resync_pulse(rsp),
    .osc_source_sel_in3(o3), .osc_source_sel_in2(o2),
    .osc_source_sel_in1(o1), .divider_resync_enable(rse),
    .dynamic_route_in3(d3), .dynamic_route_in2(d2),
    .dynamic_route_in1(d1), .static_mux_sel_in3(s3),
    .static_mux_sel_in2(s2), .static_mux_sel_in1(s1),
    .vco_range_field(vco), .system_delay_insert(sysd),
    .feedback_delay_code(fbd), .feedback_source_sel(fbs),
    .local_out3_delay(l3), .local_out2_delay(l2),
    .global_out3_delay(g3), .global_out2_delay(g2),
    .global_primary_delay(g1), .phase_sel_out3(ph3),
    .phase_sel_out2(ph2));
  ccc_pll_model u_pll (.clk(clk), .rst(rst), .run(run),
    .config_update_strobe(upd), .pll_lock_raw(raw));

  // ==========================================================
  // shared tasks
  task automatic close_out;
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // one APB transfer; request held until pready seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) chk("pready", 1'b1, pready);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(nm, e, rd);
    chk({nm, " err"}, ee, er);
  endtask
  task automatic put(input ccc_cfg_t v);
    apb(1'b1, OFF_CFG_LO, v[63:32], 4'hF);
    apb(1'b1, OFF_CFG_HI, {12'h0, v[83:64]}, 4'hF);
  endtask
  task automatic apply(input ccc_cfg_t v);
    apb(1'b1, OFF_CTRL, 32'h1, 4'h1);
    @(posedge clk);
    chk("strobe", 1'b1, upd);
    chk("resync", 1'b1, rsp);
    chk("word", v, act);
  endtask
  task automatic wait_lock(input logic e);
    int n;
    n = 0;
    while (locked !== e && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("locked", e, locked);
  endtask

  // ==========================================================
  // scenarios
  task automatic do_reset(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
    cur = '0;
    cur[BIT_RESYNC] = 1'b1;
    @(posedge clk);
    chk("reset word", cur, act);
    chk("reset strobe", 1'b0, upd);
    rchk("cfg hi", OFF_CFG_HI, 32'h10000, 1'b0);
  endtask
  task automatic t_shadow(input ccc_cfg_t v);
    ccc_cfg_t e;
    e = v;
    e[BIT_RESYNC] = 1'b1;
    put(v);
    chk("held", cur, act);
    rchk("pending", OFF_STATUS, 32'h2, 1'b0);
    rchk("cfg lo", OFF_CFG_LO, v[63:32], 1'b0);
    rchk("cfg hi", OFF_CFG_HI, {12'h0, e[83:64]}, 1'b0);
    apply(e);
    rchk("act hi", OFF_ACT_HI, {12'h0, e[83:64]}, 1'b0);
    cur = e;
  endtask
  task automatic t_fbsel;
    ccc_cfg_t v;
    v = cur;
    v[FBSEL_HI:FBSEL_LO] = FBSEL_RESERVED;
    v[VCO_HI:VCO_LO] = ~cur[VCO_HI:VCO_LO];
    put(v);
    v[FBSEL_HI:FBSEL_LO] = cur[FBSEL_HI:FBSEL_LO];
    apply(v);
    rchk("fb pend", OFF_STATUS, 32'h2, 1'b0);
    put(v);
    cur = v;
  endtask
  task automatic t_bus;
    rchk("unmapped", 8'h18, 32'h0, 1'b1);
    apb(1'b1, OFF_ACT_LO, 32'hFFFFFFFF, 4'hF);
    rchk("act lo", OFF_ACT_LO, cur[63:32], 1'b0);
    apb(1'b1, OFF_CFG_LO, 32'hFFFFFFFF, 4'h1);
    rchk("lane", OFF_CFG_LO, {cur[63:40], 8'hFF}, 1'b0);
    apb(1'b1, OFF_CFG_LO, cur[63:32], 4'hF);
  endtask
  task automatic t_lock;
    run <= 1'b1;
    wait_lock(1'b1);
    rchk("status", OFF_STATUS, 32'h5, 1'b0);
    apply(cur);
    @(posedge clk);
    chk("relock", 1'b0, locked);
    wait_lock(1'b1);
    run <= 1'b0;
    wait_lock(1'b0);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    do_reset(20);
    t_shadow(52'h5555555555555);
    t_shadow(52'hAAAAAAAAAAAAA);
    t_fbsel;
    t_bus;
    t_lock;
    do_reset(2);
    close_out;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    close_out;
  end
endmodule
`default_nettype wire
